/* logic/tcb_pkg.sv */
// ----------------------------------------
// shared constants for compare-b output block
// ----------------------------------------
`default_nettype none
package tcb_pkg;
    // bus and data widths
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 10;
    localparam int NPIN   = 3;

    // register offsets
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_RUN    = 4'h1;
    localparam logic [3:0] OFS_CNT_LO = 4'h2;
    localparam logic [3:0] OFS_CNT_HI = 4'h3;
    localparam logic [3:0] OFS_CA_LO  = 4'h4;
    localparam logic [3:0] OFS_CA_HI  = 4'h5;
    localparam logic [3:0] OFS_CB_LO  = 4'h6;
    localparam logic [3:0] OFS_CB_HI  = 4'h7;

    // control register field positions
    localparam int CTL_MODE_HI = 7;
    localparam int CTL_MODE_LO = 6;
    localparam int CTL_ACT_HI  = 5;
    localparam int CTL_ACT_LO  = 4;
    localparam int CTL_INIT    = 3;
    localparam int CTL_INV     = 2;
    localparam int CTL_ALN_HI  = 1;
    localparam int CTL_ALN_LO  = 0;
    localparam int RUN_BIT     = 0;

    // reset values and counter limits
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [9:0] CNT_RST  = 10'h000;
    localparam logic [9:0] CNT_MAX  = 10'h3FF;
    localparam logic [9:0] CNT_ONE  = 10'h001;
    localparam logic [5:0] HI_PAD   = 6'h00;

    // pin action codes on a match
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_LOW  = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOG  = 2'h3;

    // pwm alignment codes
    localparam logic [1:0] ALN_EDGE = 2'h0;
    localparam logic [1:0] ALN_UP   = 2'h1;
    localparam logic [1:0] ALN_DN   = 2'h2;
    localparam logic [1:0] ALN_BOTH = 2'h3;

    // operating mode of comparator b
    typedef enum logic [1:0] {
        MODE_CMP = 2'b00,
        MODE_CAP = 2'b01,
        MODE_PWM = 2'b10,
        MODE_TMR = 2'b11
    } tcb_mode_t;

    // does a match count in this counting direction
    function automatic logic tcb_dir_ok(input logic [1:0] aln, input logic down);
        unique case (aln)
            ALN_UP:  tcb_dir_ok = ~down;
            ALN_DN:  tcb_dir_ok = down;
            default: tcb_dir_ok = 1'b1;
        endcase
    endfunction
endpackage
`default_nettype wire

/* logic/tcb_pin_drv.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// output pin driver for comparator b
// ----------------------------------------
module tcb_pin_drv (
    input  wire logic                  mclk,
    input  wire logic                  reset,
    input  wire tcb_pkg::tcb_mode_t    mode,
    input  wire logic [1:0]            action,
    input  wire logic                  init_lvl,
    input  wire logic                  invert,
    input  wire logic                  run,
    input  wire logic                  run_rise,
    input  wire logic                  match_b,
    input  wire logic                  pwm_on,
    output logic [tcb_pkg::NPIN-1:0]   pin_r,
    output logic                       oe_n_r
);
    logic raw_r;   // level before polarity
    logic raw_nxt;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    // ----------------------------------------
    // next raw level
    // ----------------------------------------
    always_comb begin
        raw_nxt = raw_r;
        if (mode == tcb_pkg::MODE_CMP) begin
            if (run_rise) begin
                raw_nxt = init_lvl;
            end else if (match_b) begin
                unique case (action)
                    tcb_pkg::ACT_LOW:  raw_nxt = 1'b0;
                    tcb_pkg::ACT_HIGH: raw_nxt = 1'b1;
                    tcb_pkg::ACT_TOG:  raw_nxt = ~raw_r;
                    default:           raw_nxt = raw_r;
                endcase
            end
        end else if (mode == tcb_pkg::MODE_PWM) begin
            raw_nxt = (run && pwm_on) ? init_lvl : ~init_lvl;
        end
    end

    // raw level store; capture and timer modes just hold
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            raw_r <= 1'b0;
        end else begin
            raw_r <= raw_nxt;
        end
    end

    // ----------------------------------------
    // pins, one flop each
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < tcb_pkg::NPIN; gi++) begin : g_pin
            always_ff @(posedge mclk or posedge reset) begin
                if (reset) begin
                    pin_r[gi] <= 1'b0;
                end else if (mode == tcb_pkg::MODE_CMP || mode == tcb_pkg::MODE_PWM) begin
                    pin_r[gi] <= raw_nxt ^ invert;
                end
            end
        end
    endgenerate

    // pins released in timer and capture modes
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            oe_n_r <= 1'b1;
        end else begin
            oe_n_r <= ~(mode == tcb_pkg::MODE_CMP || mode == tcb_pkg::MODE_PWM);
        end
    end

    property p_init_load;
        (mode == tcb_pkg::MODE_CMP) && run_rise |=> pin_r[0] == ($past(init_lvl) ^ $past(invert));
    endproperty
    a_init_load: assert property (p_init_load) else $error("initial level not loaded");

    property p_no_action;
        (mode == tcb_pkg::MODE_CMP) && match_b && !run_rise && action == tcb_pkg::ACT_NONE
            |=> raw_r == $past(raw_r);
    endproperty
    a_no_action: assert property (p_no_action) else $error("pin moved with no action");

    property p_pwm_level;
        (mode == tcb_pkg::MODE_PWM) |=> pin_r[0] ==
            ((($past(run) && $past(pwm_on)) ? $past(init_lvl) : !$past(init_lvl)) ^ $past(invert));
    endproperty
    a_pwm_level: assert property (p_pwm_level) else $error("pwm level wrong");

    property p_timer_idle;
        (mode == tcb_pkg::MODE_TMR) |=> oe_n_r && $stable(pin_r);
    endproperty
    a_timer_idle: assert property (p_timer_idle) else $error("pins touched in timer mode");

    property p_pins_same;
        pin_r[0] == pin_r[1] && pin_r[1] == pin_r[2];
    endproperty
    a_pins_same: assert property (p_pins_same) else $error("pins differ");
endmodule
`default_nettype wire

/* logic/tcb_top.sv */
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module tcb_top (
    input  wire logic                        mclk,
    input  wire logic                        reset,
    input  wire logic [tcb_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [tcb_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [tcb_pkg::DATA_W-1:0]  reg_rdata,
    output logic                             second_out_pin_0,
    output logic                             second_out_pin_1,
    output logic                             second_out_pin_2,
    output logic                             second_out_oe_n
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [7:0]                 ctrl_r;     // second_control_reg
    logic                       run_r;      // timer_run
    logic                       run_d_r;    // run delayed for edge
    logic [tcb_pkg::CNT_W-1:0]  cnt_r;      // live counter
    logic                       dir_r;      // 1 while counting down
    logic [tcb_pkg::CNT_W-1:0]  cmp_a_r;    // first_compare_value
    logic [tcb_pkg::CNT_W-1:0]  cmp_b_r;    // second_compare_value
    logic [7:0]                 rdata_r;    // read answer
    logic [tcb_pkg::NPIN-1:0]   pin_w;      // pin flops in driver

    // decoded control fields, run edge and match/duty flags
    tcb_pkg::tcb_mode_t mode;
    logic [1:0]         action;
    logic [1:0]         align;
    logic               run_rise;
    logic               centre;
    logic               match_b;
    logic               pwm_on;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    assign mode   = tcb_pkg::tcb_mode_t'(ctrl_r[tcb_pkg::CTL_MODE_HI:tcb_pkg::CTL_MODE_LO]);
    assign action = ctrl_r[tcb_pkg::CTL_ACT_HI:tcb_pkg::CTL_ACT_LO];
    assign align  = ctrl_r[tcb_pkg::CTL_ALN_HI:tcb_pkg::CTL_ALN_LO];
    assign run_rise = run_r & ~run_d_r;
    // centre counting only applies in pwm mode
    assign centre = (mode == tcb_pkg::MODE_PWM) && (align != tcb_pkg::ALN_EDGE);
    assign match_b = run_r && (cnt_r == cmp_b_r) && tcb_pkg::tcb_dir_ok(align, dir_r);
    // duty comparison; an up/down count makes it centred
    assign pwm_on = cnt_r < cmp_b_r;

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    // control byte and run bit
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ctrl_r <= tcb_pkg::BYTE_RST;
            run_r  <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == tcb_pkg::OFS_CTRL) begin
                ctrl_r <= reg_wdata;
            end
            if (reg_addr == tcb_pkg::OFS_RUN) begin
                run_r <= reg_wdata[tcb_pkg::RUN_BIT];
            end
        end
    end

    // run delay for rising edge
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            run_d_r <= 1'b0;
        end else begin
            run_d_r <= run_r;
        end
    end

    // compare values; only bits 9:8 kept in high bytes
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cmp_a_r <= tcb_pkg::CNT_RST;
            cmp_b_r <= tcb_pkg::CNT_RST;
        end else if (reg_wr) begin
            unique case (reg_addr)
                tcb_pkg::OFS_CA_LO: cmp_a_r[7:0] <= reg_wdata;
                tcb_pkg::OFS_CA_HI: cmp_a_r[9:8] <= reg_wdata[1:0];
                tcb_pkg::OFS_CB_LO: cmp_b_r[7:0] <= reg_wdata;
                tcb_pkg::OFS_CB_HI: cmp_b_r[9:8] <= reg_wdata[1:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // counter
    // ----------------------------------------
    // bus never touches counter
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_r <= tcb_pkg::CNT_RST;
            dir_r <= 1'b0;
        end else if (run_rise) begin
            // restart from zero, counting up
            cnt_r <= tcb_pkg::CNT_RST;
            dir_r <= 1'b0;
        end else if (run_r) begin
            if (!centre) begin
                // edge count wraps at the top
                cnt_r <= cnt_r + tcb_pkg::CNT_ONE;
                dir_r <= 1'b0;
            end else if (!dir_r) begin
                // going up; turn at the top
                if (cnt_r == tcb_pkg::CNT_MAX) begin
                    dir_r <= 1'b1;
                    cnt_r <= cnt_r - tcb_pkg::CNT_ONE;
                end else begin
                    cnt_r <= cnt_r + tcb_pkg::CNT_ONE;
                end
            end else begin
                // going down; turn at zero
                if (cnt_r == tcb_pkg::CNT_RST) begin
                    dir_r <= 1'b0;
                    cnt_r <= cnt_r + tcb_pkg::CNT_ONE;
                end else begin
                    cnt_r <= cnt_r - tcb_pkg::CNT_ONE;
                end
            end
        end
    end

    // ----------------------------------------
    // register reads
    // ----------------------------------------
    // data valid only in the cycle after the strobe
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rdata_r <= tcb_pkg::BYTE_RST;
        end else if (reg_rd) begin
            unique case (reg_addr)
                tcb_pkg::OFS_CTRL:   rdata_r <= ctrl_r;
                tcb_pkg::OFS_RUN:    rdata_r <= {7'h00, run_r};
                tcb_pkg::OFS_CNT_LO: rdata_r <= cnt_r[7:0];
                tcb_pkg::OFS_CNT_HI: rdata_r <= {tcb_pkg::HI_PAD, cnt_r[9:8]};
                tcb_pkg::OFS_CA_LO:  rdata_r <= cmp_a_r[7:0];
                tcb_pkg::OFS_CA_HI:  rdata_r <= {tcb_pkg::HI_PAD, cmp_a_r[9:8]};
                tcb_pkg::OFS_CB_LO:  rdata_r <= cmp_b_r[7:0];
                tcb_pkg::OFS_CB_HI:  rdata_r <= {tcb_pkg::HI_PAD, cmp_b_r[9:8]};
                default:             rdata_r <= tcb_pkg::BYTE_RST;
            endcase
        end else begin
            rdata_r <= tcb_pkg::BYTE_RST;
        end
    end

    assign reg_rdata = rdata_r;

    // ----------------------------------------
    // pin driver
    // ----------------------------------------
    // pwm relies on software codes
    tcb_pin_drv u_drv (
        .mclk     (mclk),
        .reset    (reset),
        .mode     (mode),
        .action   (action),
        .init_lvl (ctrl_r[tcb_pkg::CTL_INIT]),
        .invert   (ctrl_r[tcb_pkg::CTL_INV]),
        .run      (run_r),
        .run_rise (run_rise),
        .match_b  (match_b),
        .pwm_on   (pwm_on),
        .pin_r    (pin_w),
        .oe_n_r   (second_out_oe_n)
    );

    assign second_out_pin_0 = pin_w[0];
    assign second_out_pin_1 = pin_w[1];
    assign second_out_pin_2 = pin_w[2];

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_cnt_lo_read;
        reg_rd && reg_addr == tcb_pkg::OFS_CNT_LO |=> reg_rdata == $past(cnt_r[7:0]);
    endproperty
    a_cnt_lo_read: assert property (p_cnt_lo_read) else $error("counter low read wrong");

    property p_cnt_hi_read;
        reg_rd && reg_addr == tcb_pkg::OFS_CNT_HI |=> reg_rdata == {6'h00, $past(cnt_r[9:8])};
    endproperty
    a_cnt_hi_read: assert property (p_cnt_hi_read) else $error("counter high read wrong");

    // a write lands in the low byte of compare a
    property p_cmpa_lo;
        reg_wr && reg_addr == tcb_pkg::OFS_CA_LO |=> cmp_a_r[7:0] == $past(reg_wdata);
    endproperty
    a_cmpa_lo: assert property (p_cmpa_lo) else $error("compare a low lost");

    // compare a low byte reads back what is stored
    property p_cmpa_lo_rd;
        reg_rd && reg_addr == tcb_pkg::OFS_CA_LO |=> reg_rdata == $past(cmp_a_r[7:0]);
    endproperty
    a_cmpa_lo_rd: assert property (p_cmpa_lo_rd) else $error("compare a low read wrong");

    property p_cmpa_hi;
        reg_wr && reg_addr == tcb_pkg::OFS_CA_HI |=> cmp_a_r[9:8] == $past(reg_wdata[1:0]);
    endproperty
    a_cmpa_hi: assert property (p_cmpa_hi) else $error("compare a high lost");

    // unused bits of the compare a high byte
    property p_cmpa_hi_rd;
        reg_rd && reg_addr == tcb_pkg::OFS_CA_HI |=> reg_rdata[7:2] == 6'h00;
    endproperty
    a_cmpa_hi_rd: assert property (p_cmpa_hi_rd) else $error("compare a pad not zero");

    property p_cmpb_lo;
        reg_wr && reg_addr == tcb_pkg::OFS_CB_LO |=> cmp_b_r[7:0] == $past(reg_wdata);
    endproperty
    a_cmpb_lo: assert property (p_cmpb_lo) else $error("compare b low lost");

    // compare b high byte keeps bits 9:8 only
    property p_cmpb_hi;
        reg_wr && reg_addr == tcb_pkg::OFS_CB_HI |=> cmp_b_r[9:8] == $past(reg_wdata[1:0]);
    endproperty
    a_cmpb_hi: assert property (p_cmpb_hi) else $error("compare b high lost");

    property p_cmpb_hi_rd;
        reg_rd && reg_addr == tcb_pkg::OFS_CB_HI |=> reg_rdata[7:2] == 6'h00;
    endproperty
    a_cmpb_hi_rd: assert property (p_cmpb_hi_rd) else $error("compare b pad not zero");

    property p_cnt_nowrite;
        !run_r && !run_d_r && reg_wr && (reg_addr == tcb_pkg::OFS_CNT_LO || reg_addr == tcb_pkg::OFS_CNT_HI)
            |=> $stable(cnt_r);
    endproperty
    a_cnt_nowrite: assert property (p_cnt_nowrite) else $error("counter written");

    property p_centre_turn;
        run_r && !run_rise && centre && !dir_r && cnt_r == tcb_pkg::CNT_MAX |=> dir_r;
    endproperty
    a_centre_turn: assert property (p_centre_turn) else $error("centre count did not turn");

    // ----------------------------------------
    // counter and alignment checks
    // ----------------------------------------
    // bus traffic never upsets an edge count
    property p_cnt_undisturbed;
        run_r && !run_rise && !centre |=> cnt_r == $past(cnt_r) + tcb_pkg::CNT_ONE;
    endproperty
    a_cnt_undisturbed: assert property (p_cnt_undisturbed) else $error("counter step lost");

    // a stopped counter holds whatever the bus does
    property p_stopped_hold;
        !run_r |=> $stable(cnt_r);
    endproperty
    a_stopped_hold: assert property (p_stopped_hold) else $error("stopped counter moved");

    // run start clears the count, counting up
    property p_run_restart;
        run_rise |=> cnt_r == tcb_pkg::CNT_RST && !dir_r;
    endproperty
    a_run_restart: assert property (p_run_restart) else $error("run start did not clear");

    // centre count turns back up at zero
    property p_centre_bottom;
        run_r && !run_rise && centre && dir_r && cnt_r == tcb_pkg::CNT_RST |=> !dir_r;
    endproperty
    a_centre_bottom: assert property (p_centre_bottom) else $error("centre count did not turn at zero");

    // down-only alignment ignores a match on the way up
    property p_dn_nomatch;
        align == tcb_pkg::ALN_DN && !dir_r |-> !match_b;
    endproperty
    a_dn_nomatch: assert property (p_dn_nomatch) else $error("match taken counting up");

    // up-only alignment ignores a match on the way down
    property p_up_nomatch;
        align == tcb_pkg::ALN_UP && dir_r |-> !match_b;
    endproperty
    a_up_nomatch: assert property (p_up_nomatch) else $error("match taken counting down");
endmodule
`default_nettype wire

/* testbench/tcb_load.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// far-side load on the compare-b pins
// ----------------------------------------
module tcb_load (
    input  wire logic        mclk,
    input  wire logic        pin_0,
    input  wire logic        pin_1,
    input  wire logic        pin_2,
    input  wire logic        oe_n,
    input  wire logic        clr,
    output logic             level,
    output logic [15:0]      high_cnt,
    output logic             split_r
);
    // released pin falls to the pull-down, never keeps its last value
    assign level = oe_n ? 1'b0 : pin_0;

    // high cycles seen since the last clear
    always_ff @(posedge mclk) begin
        if (clr) begin
            high_cnt <= 16'h0000;
        end else if (level === 1'b1) begin
            high_cnt <= high_cnt + 16'h0001;
        end
    end

    // sticky flag: the three pins should never differ while driven
    always_ff @(posedge mclk) begin
        if (clr) begin
            split_r <= 1'b0;
        end else if (!oe_n && ((pin_0 !== pin_1) || (pin_0 !== pin_2))) begin
            split_r <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* testbench/enhanced_timer_compare_b_output_bench.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// bench for the compare-b output block
// ----------------------------------------
module enhanced_timer_compare_b_output_bench;
    logic        mclk;                  // 100 MHz clock
    logic        reset;                 // async reset, high
    logic [3:0]  reg_addr;              // register index
    logic [7:0]  reg_wdata;             // write data
    logic        reg_wr;                // write strobe
    logic        reg_rd;                // read strobe
    logic [7:0]  reg_rdata;             // read data
    logic        pin_0;                 // output pins
    logic        pin_1;
    logic        pin_2;
    logic        oe_n;                  // pin drive enable, low active
    logic        clr;                   // clears load counters
    logic        level;                 // wire level at the load
    logic [15:0] high_cnt;              // high cycles seen
    logic        split_r;               // pins disagreed
    int          fail_count;            // mismatches
    int          checks_done;           // comparisons

    tcb_top dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .second_out_pin_0(pin_0),
        .second_out_pin_1(pin_1), .second_out_pin_2(pin_2), .second_out_oe_n(oe_n));
    tcb_load load (.mclk(mclk), .pin_0(pin_0), .pin_1(pin_1), .pin_2(pin_2), .oe_n(oe_n),
        .clr(clr), .level(level), .high_cnt(high_cnt), .split_r(split_r));

    // ----------------------------------------
    // shared helpers
    // ----------------------------------------
    // free-running clock, 10 ns period
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    // one-cycle read strobe, data taken in the following cycle only
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // stop, reconfigure, restart so the run bit sees a rising edge
    task automatic start(input logic [7:0] ctl);
        wr(tcb_pkg::OFS_RUN, 8'h00);
        wr(tcb_pkg::OFS_CTRL, ctl);
        wr(tcb_pkg::OFS_RUN, 8'h01);
    endtask

    // count high cycles at the load over n cycles
    task automatic measure(input int n);
        @(posedge mclk);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic conclude;
        if (fail_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // every register reads zero after reset, unmapped reads zero too
    task automatic t_reset_values;
        logic [7:0] d;
        wr(tcb_pkg::OFS_CNT_LO, 8'hFF);
        wr(tcb_pkg::OFS_CNT_HI, 8'hFF);
        for (int i = 0; i < 8; i++) begin
            rd(i[3:0], d);
            chk(d, 16'h0000, "reset value");
        end
        rd(4'h9, d);
        chk(d, 16'h0000, "unmapped read");
    endtask

    // compare bytes keep data, unused high bits read zero
    task automatic t_compare_regs;
        logic [7:0] d;
        wr(tcb_pkg::OFS_CA_LO, 8'hA5);
        wr(tcb_pkg::OFS_CA_HI, 8'hFF);
        wr(tcb_pkg::OFS_CB_LO, 8'h5A);
        wr(tcb_pkg::OFS_CB_HI, 8'hFE);
        rd(tcb_pkg::OFS_CA_LO, d);
        chk(d, 16'h00A5, "compare a low");
        rd(tcb_pkg::OFS_CA_HI, d);
        chk(d, 16'h0003, "compare a high");
        rd(tcb_pkg::OFS_CB_LO, d);
        chk(d, 16'h005A, "compare b low");
        rd(tcb_pkg::OFS_CB_HI, d);
        chk(d, 16'h0002, "compare b high");
    endtask

    // counter reads live and ignores writes
    task automatic t_counter;
        logic [7:0] a;
        logic [7:0] b;
        start(8'h00);
        rd(tcb_pkg::OFS_CNT_LO, a);
        rd(tcb_pkg::OFS_CNT_LO, b);
        chk(b, 16'(a + 8'h02), "counter low live");
        rd(tcb_pkg::OFS_CNT_HI, a);
        chk(a, 16'h0000, "counter high early");
        repeat (300) @(posedge mclk);
        wr(tcb_pkg::OFS_CNT_HI, 8'hFF);
        rd(tcb_pkg::OFS_CNT_HI, a);
        chk(a, 16'h0001, "counter high, write ignored");
    endtask

    // compare mode: start level, then each pin action on a match
    task automatic t_compare_out;
        logic [4:0] tab [6] = '{5'b00_1_0_1, 5'b01_1_0_0, 5'b10_0_0_1,
                               5'b11_0_0_1, 5'b11_1_1_1, 5'b10_0_1_0};
        wr(tcb_pkg::OFS_CB_LO, 8'h10);
        wr(tcb_pkg::OFS_CB_HI, 8'h00);
        for (int i = 0; i < 6; i++) begin
            start({2'b00, tab[i][4:1], 2'b00});
            repeat (3) @(posedge mclk);
            #1;
            chk(pin_0, 16'(tab[i][2] ^ tab[i][1]), "start level");
            chk(oe_n, 16'h0000, "pins driven");
            repeat (40) @(posedge mclk);
            #1;
            chk({pin_2, pin_1, pin_0}, {13'h0, {3{tab[i][0]}}}, "after match");
        end
    endtask

    // timer mode: pins released, start level ignored
    task automatic t_timer_mode;
        start({2'b11, tcb_pkg::ACT_TOG, 1'b1, 1'b0, 2'b00});
        repeat (40) @(posedge mclk);
        #1;
        chk(oe_n, 16'h0001, "timer mode released");
        chk(pin_0, 16'h0000, "timer mode pins hold");
    endtask

    // edge-aligned pwm duty for each active level and polarity
    task automatic t_pwm_edge;
        logic [17:0] tab [4] = '{{2'b10, 16'h0100}, {2'b00, 16'h0300}, {2'b11, 16'h0300}, {2'b01, 16'h0100}};
        wr(tcb_pkg::OFS_CB_LO, 8'h00);
        wr(tcb_pkg::OFS_CB_HI, 8'h01);
        for (int i = 0; i < 4; i++) begin
            start({2'b10, tcb_pkg::ACT_HIGH, tab[i][17:16], tcb_pkg::ALN_EDGE});
            repeat (5) @(posedge mclk);
            measure(1024);
            chk(high_cnt, tab[i][15:0], "pwm duty");
            chk(split_r, 16'h0000, "pins agree");
        end
    endtask

    // centre codes: one up/down period of 2046 has 511 counts below 0x100
    task automatic t_pwm_centre;
        for (int i = 1; i < 4; i++) begin
            start({2'b10, tcb_pkg::ACT_HIGH, 2'b10, i[1:0]});
            repeat (5) @(posedge mclk);
            measure(2046);
            chk(high_cnt, 16'h01FF, "centre duty");
        end
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        fail_count  = 0;
        checks_done = 0;
        reset       = 1'b1;
        reg_addr    = 4'h0;
        reg_wdata   = 8'h00;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        clr         = 1'b1;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        t_reset_values();
        t_compare_regs();
        t_counter();
        t_compare_out();
        t_timer_mode();
        t_pwm_edge();
        t_pwm_centre();
        conclude();
    end

    // run needs about 11k cycles; far beyond that means a hang
    initial begin
        repeat (40000) @(posedge mclk);
        fail_count++;
        conclude();
    end
endmodule
`default_nettype wire
